// ==== rtl/wst_top.sv ====
// Windowed supervisor timer with register port and chip reset output
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - Chip reset when counter expires unfed
// - Window mode: early feed counts as fault
// - Warning flag at programmable count value
// - Enable sticks until reset or event
// - Bad feed sequence: reset or interrupt
// - Readable flag: last reset by timer
// - 24-bit constant, minimum value 255 (0xff)
// - Dedicated oscillator requested while enabled
module wst_top (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire wst_pkg::wst_bus_req_s bus_req,
  output logic [31:0]                bus_rdata,
  input  wire logic                  supervisor_osc_clock,
  output logic                       osc_enable,
  output logic                       chip_reset,
  output logic                       warn_irq
);
  import wst_pkg::*;

  // ********************************************************************
  // Oscillator sampling and prescaler
  // ********************************************************************
  // Oscillator edges are found in the bus clock; 500 kHz is far below clk
  logic       osc_s1;
  logic       osc_s2;
  logic       osc_s3;
  logic [1:0] presc;
  logic [1:0] next_presc;
  logic       tick;

  always_comb begin
    next_presc = presc;
    tick       = 1'b0;
    if (osc_s2 && !osc_s3) begin
      next_presc = presc + 2'h1;
      tick       = (presc == WST_PRESCALE);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      presc  <= 2'h0;
    end else begin
      osc_s1 <= supervisor_osc_clock;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      presc  <= next_presc;
    end
  end

  // ********************************************************************
  // Registers, feed sequence and counter
  // ********************************************************************
  logic        enable, reset_en, win_en, fault_int;
  logic        to_flag, warn_flag, fault_flag;
  logic [23:0] reload, warn_val, window, count;
  logic        feed_pend, chip_rst_q;
  wst_feed_e   feed_st;
  logic        next_enable, next_reset_en, next_win_en, next_fault_int;
  logic        next_to_flag, next_warn_flag, next_fault_flag;
  logic [23:0] next_reload, next_warn_val, next_window, next_count;
  logic        next_feed_pend, next_chip_rst;
  wst_feed_e   next_feed_st;
  logic        wr_mode, wr_feed, feed_ok, feed_bad, win_bad, expire, fault, event_hit;
  logic        irq_level;
  logic        next_irq_level;

  // Address decode of a write strobe, shared by every writable register
  function automatic logic wr_hit(input wst_bus_req_s req, input logic [7:0] ofs);
    return req.wr && (req.addr == ofs);
  endfunction

  always_comb begin
    wr_mode  = wr_hit(bus_req, WST_OFS_MODE);
    wr_feed  = wr_hit(bus_req, WST_OFS_FEED);
    feed_ok  = wr_feed && (feed_st == WST_FEED_ARMED)
               && (bus_req.wdata[7:0] == WST_FEED_SECOND);
    feed_bad = wr_feed && !feed_ok
               && !((feed_st == WST_FEED_IDLE) && (bus_req.wdata[7:0] == WST_FEED_FIRST));
    win_bad  = feed_ok && enable && win_en && (count > window);
    fault    = enable && (feed_bad || win_bad);
    expire   = enable && tick && !feed_pend && (count == 24'h000000);
    event_hit = expire || fault;

    next_feed_st = feed_st;
    if (wr_feed) begin
      case (feed_st)
        WST_FEED_IDLE:  next_feed_st = feed_bad ? WST_FEED_IDLE : WST_FEED_ARMED;
        WST_FEED_ARMED: next_feed_st = WST_FEED_IDLE;
        default:        next_feed_st = WST_FEED_IDLE;
      endcase
    end

    next_enable    = enable;
    next_reset_en  = reset_en;
    next_win_en    = win_en;
    next_fault_int = fault_int;
    next_to_flag   = to_flag;
    next_warn_flag = warn_flag;
    next_fault_flag = fault_flag;
    if (wr_mode) begin
      // Enable and reset select can only be set by software
      next_enable    = enable | bus_req.wdata[WST_BIT_ENABLE];
      next_reset_en  = reset_en | bus_req.wdata[WST_BIT_RESET_EN];
      next_win_en    = bus_req.wdata[WST_BIT_WIN_EN];
      next_fault_int = bus_req.wdata[WST_BIT_FAULT_INT];
      if (!bus_req.wdata[WST_BIT_TO_FLAG]) next_to_flag = 1'b0;
      if (bus_req.wdata[WST_BIT_WARN_FLAG]) next_warn_flag = 1'b0;
      if (bus_req.wdata[WST_BIT_FAULT_FLG]) next_fault_flag = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (enable && tick && !feed_pend && (count == warn_val) && (count != 24'h000000)) begin
      next_warn_flag = 1'b1;
    end
    if (fault) next_fault_flag = 1'b1;
    if (expire || (fault && !fault_int)) begin
      next_to_flag = 1'b1;
    end
    if (event_hit) next_enable = 1'b0;

    next_reload = reload;
    if (wr_hit(bus_req, WST_OFS_CONST)) begin
      next_reload = (bus_req.wdata[23:0] < WST_CONST_MIN) ? WST_CONST_MIN
                    : bus_req.wdata[23:0];
    end
    next_warn_val = warn_val;
    if (wr_hit(bus_req, WST_OFS_WARN)) next_warn_val = bus_req.wdata[23:0];
    next_window = window;
    if (wr_hit(bus_req, WST_OFS_WINDOW)) next_window = bus_req.wdata[23:0];

    // Feeds wait for the next oscillator tick before touching the counter
    next_feed_pend = feed_pend;
    if (tick) next_feed_pend = 1'b0;
    if (feed_ok && !win_bad) next_feed_pend = 1'b1;
    if (event_hit) next_feed_pend = 1'b0;

    next_count = count;
    if (!enable) begin
      next_count = reload;
    end else if (tick) begin
      if (feed_pend) next_count = reload;
      else if (count != 24'h000000) next_count = count - 24'h000001;
    end

    next_chip_rst = reset_en && event_hit && !(fault && !expire && fault_int);
    // Built from next values so the registered pin has no extra cycle of lag
    next_irq_level = next_warn_flag | next_fault_flag | (next_to_flag & ~next_reset_en);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable     <= 1'b0;
      reset_en   <= 1'b0;
      win_en     <= 1'b0;
      fault_int  <= 1'b0;
      to_flag    <= 1'b0;
      warn_flag  <= 1'b0;
      fault_flag <= 1'b0;
      reload     <= WST_CONST_RST;
      warn_val   <= WST_WARN_RST;
      window     <= WST_WINDOW_RST;
      count      <= WST_CONST_RST;
      feed_pend  <= 1'b0;
      feed_st    <= WST_FEED_IDLE;
      chip_rst_q <= 1'b0;
      irq_level  <= 1'b0;
    end else begin
      enable     <= next_enable;
      reset_en   <= next_reset_en;
      win_en     <= next_win_en;
      fault_int  <= next_fault_int;
      to_flag    <= next_to_flag;
      warn_flag  <= next_warn_flag;
      fault_flag <= next_fault_flag;
      reload     <= next_reload;
      warn_val   <= next_warn_val;
      window     <= next_window;
      count      <= next_count;
      feed_pend  <= next_feed_pend;
      feed_st    <= next_feed_st;
      chip_rst_q <= next_chip_rst;
      irq_level  <= next_irq_level;
    end
  end

  // ********************************************************************
  // Read port and outputs
  // ********************************************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        WST_OFS_MODE:   next_rdata = {25'h0000000, fault_flag, fault_int, win_en,
                                      warn_flag, to_flag, reset_en, enable};
        WST_OFS_CONST:  next_rdata = {8'h00, reload};
        WST_OFS_COUNT:  next_rdata = {8'h00, count};
        WST_OFS_WARN:   next_rdata = {8'h00, warn_val};
        WST_OFS_WINDOW: next_rdata = {8'h00, window};
        default:        next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 32'h00000000;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  assign osc_enable = enable;
  assign chip_reset = chip_rst_q;
  // Interrupt level; without reset select the expiry also shows here
  assign warn_irq   = irq_level;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_expire_reset: assert property (expire && reset_en |=> chip_reset)
    else $error("expiry did not reset chip");
  a_early_fault: assert property (win_bad |=> fault_flag && !enable)
    else $error("early feed not a fault");
  a_warn_set: assert property (enable && tick && !feed_pend && count == warn_val
    && count != 24'h000000 |=> warn_flag)
    else $error("warning flag missing");
  a_enable_sticky: assert property (enable && !event_hit |=> enable)
    else $error("enable dropped without event");
  a_bad_feed: assert property (fault && !fault_int && reset_en |=> chip_reset)
    else $error("bad feed not acted on");
  a_cause_flag: assert property (chip_reset |-> to_flag)
    else $error("reset cause flag clear");
  a_const_min: assert property (reload >= WST_CONST_MIN)
    else $error("reload below minimum");
  a_osc_req: assert property ($fell(osc_enable) |-> $past(event_hit))
    else $error("oscillator released without event");
  a_count_step: assert property (enable && tick && !feed_pend && count != 24'h000000
    |=> count == $past(count) - 24'h000001)
    else $error("counter did not step");
  a_feed_tick: assert property (enable && feed_pend && !tick && !event_hit
    |=> count == $past(count))
    else $error("feed applied off tick");
  a_read_once: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h00000000)
    else $error("read data outside slot");

  c_timeout: cover property (expire ##1 chip_reset);
  c_feed_good: cover property (feed_ok && !win_bad ##[1:200] tick && feed_pend);
  c_warn: cover property (!warn_flag ##1 warn_flag);
  c_fault_int: cover property (fault && fault_int);

endmodule

// ==== rtl/wst_pkg.sv ====
// Package of constants and types for the windowed supervisor timer
package wst_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] WST_OFS_MODE     = 8'h00;
  localparam logic [7:0] WST_OFS_CONST    = 8'h04;
  localparam logic [7:0] WST_OFS_FEED     = 8'h08;
  localparam logic [7:0] WST_OFS_COUNT    = 8'h0c;
  localparam logic [7:0] WST_OFS_WARN     = 8'h10;
  localparam logic [7:0] WST_OFS_WINDOW   = 8'h14;

  // Mode register fields
  localparam int WST_BIT_ENABLE    = 0;
  localparam int WST_BIT_RESET_EN  = 1;
  localparam int WST_BIT_TO_FLAG   = 2;
  localparam int WST_BIT_WARN_FLAG = 3;
  localparam int WST_BIT_WIN_EN    = 4;
  localparam int WST_BIT_FAULT_INT = 5;
  localparam int WST_BIT_FAULT_FLG = 6;

  // ********************************************************************
  // Values and counts
  // ********************************************************************
  localparam logic [23:0] WST_CONST_MIN   = 24'h0000ff;
  localparam logic [23:0] WST_CONST_RST   = 24'h0000ff;
  localparam logic [23:0] WST_WARN_RST    = 24'h000000;
  localparam logic [23:0] WST_WINDOW_RST  = 24'hffffff;
  localparam logic [7:0]  WST_FEED_FIRST  = 8'haa;
  localparam logic [7:0]  WST_FEED_SECOND = 8'h55;
  localparam int          WST_OSC_KHZ     = 500;
  localparam int          WST_CLK_KHZ     = 20000;
  localparam logic [1:0]  WST_PRESCALE    = 2'h3;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } wst_bus_req_s;

  typedef enum logic [1:0] {
    WST_FEED_IDLE  = 2'b01,
    WST_FEED_ARMED = 2'b10
  } wst_feed_e;

endpackage

// ==== verification/wst_tb.sv ====
// Self-checking testbench for the windowed supervisor timer
`timescale 1ns/100ps
module tb;
  import wst_pkg::*;
  // ******************************************************************
  // Signals and model state
  // ******************************************************************
  logic         clk                  = 1'b0;
  logic         reset_n              = 1'b0;
  wst_bus_req_s bus_req              = '0;
  logic         supervisor_osc_clock = 1'b0;
  logic [31:0]  bus_rdata;
  logic         osc_enable;
  logic         chip_reset;
  logic         warn_irq;
  logic [2:0]   osc_div              = 3'h0;
  logic [31:0]  rnd                  = 32'hc246;
  logic [31:0]  v;
  int           n_fail               = 0;
  int           tests_run            = 0;
  int           n_rst                = 0;
  int           m_const              = 'h100;

  wst_top uut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .supervisor_osc_clock(supervisor_osc_clock), .osc_enable(osc_enable),
    .chip_reset(chip_reset), .warn_irq(warn_irq));

  initial begin
    forever #25 clk = ~clk;
  end
  // Oscillator far faster than nominal so a count lasts 32 clk cycles and runs stay short
  always @(posedge clk) begin
    osc_div <= osc_div + 3'h1;
    supervisor_osc_clock <= osc_div[2];
  end
  always @(posedge clk) begin
    if (chip_reset === 1'b1) n_rst++;
  end
  // ******************************************************************
  // Tasks
  // ******************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= {a, d, 2'b10};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clk);
    bus_req <= {a, 32'h0, 2'b01};
    @(posedge clk);
    bus_req <= '0;
    #1 v = bus_rdata;
    chk("register", exp, v & mask);
  endtask
  task automatic feed(input logic [7:0] first);
    wr(WST_OFS_FEED, {24'h0, first});
    wr(WST_OFS_FEED, {24'h0, WST_FEED_SECOND});
  endtask
  // Bounded wait; the latency must land inside [lo, hi]
  task automatic wait_for(input bit irq, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (((irq ? warn_irq : chip_reset) !== 1'b1) && n <= hi) begin
      @(posedge clk);
      #1 n++;
    end
    chk("latency", 32'h1, {31'h0, n >= lo && n <= hi});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Span covers the longest expected sequence with margin
  initial begin
    #(70000 * 50);
    n_fail++;
    complete_run;
  end
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  initial begin
    logic [7:0]  addr_q[$];
    logic [31:0] exp_q[$];
    addr_q = '{WST_OFS_MODE, WST_OFS_CONST, WST_OFS_COUNT, WST_OFS_WARN, WST_OFS_WINDOW, 8'h20};
    exp_q = '{32'h0, 32'h0ff, 32'h0ff, 32'h0, 32'hffffff, 32'h0};
    idle(2);
    reset_n <= 1'b1;
    foreach (addr_q[i]) rd_chk(addr_q[i], '1, exp_q[i]);
    chk("outputs", 32'h0, {29'h0, osc_enable, chip_reset, warn_irq});
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(WST_OFS_WARN, rnd & 32'hffffff);
      rd_chk(WST_OFS_WARN, '1, rnd & 32'hffffff);
    end
    wr(WST_OFS_WARN, 32'h0);
    wr(WST_OFS_CONST, 32'h10);
    rd_chk(WST_OFS_CONST, '1, 32'hff);
    wr(WST_OFS_CONST, m_const);
    rd_chk(WST_OFS_COUNT, '1, m_const);
    wr(WST_OFS_MODE, 32'h3);
    idle(2);
    chk("osc_enable", 32'h1, {31'h0, osc_enable});
    wr(WST_OFS_MODE, 32'h0);
    rd_chk(WST_OFS_MODE, 32'h3, 32'h3);
    repeat (3) begin
      idle((m_const - 56) * 32);
      feed(WST_FEED_FIRST);
    end
    chk("resets", 32'h0, n_rst);
    wait_for(1'b0, m_const * 32, (m_const + 3) * 32);
    idle(2);
    rd_chk(WST_OFS_MODE, 32'h5, 32'h4);
    chk("osc_enable", 32'h0, {31'h0, osc_enable});
    wr(WST_OFS_MODE, 32'h23);
    feed(8'h12);
    idle(2);
    chk("fault irq", 32'h1, {31'h0, warn_irq});
    rd_chk(WST_OFS_MODE, 32'h41, 32'h40);
    chk("resets", 32'h1, n_rst);
    wr(WST_OFS_MODE, 32'h40);
    idle(2);
    chk("irq clear", 32'h0, {31'h0, warn_irq});
    wr(WST_OFS_WINDOW, 32'h40);
    wr(WST_OFS_MODE, 32'h13);
    feed(WST_FEED_FIRST);
    wait_for(1'b0, 0, 100);
    wr(WST_OFS_MODE, 32'h13);
    idle((m_const - 48) * 32);
    feed(WST_FEED_FIRST);
    idle(100 * 32);
    chk("resets", 32'h2, n_rst);
    @(posedge clk);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    rd_chk(WST_OFS_MODE, 32'h1, 32'h0);
    wr(WST_OFS_CONST, m_const);
    wr(WST_OFS_WARN, 32'h80);
    wr(WST_OFS_MODE, 32'h1);
    wait_for(1'b1, (m_const - 'h82) * 32, (m_const - 'h7e) * 32);
    rd_chk(WST_OFS_MODE, 32'h8, 32'h8);
    wr(WST_OFS_MODE, 32'h8);
    idle(2);
    chk("warn clear", 32'h0, {31'h0, warn_irq});
    wait_for(1'b1, (m_const / 2 - 2) * 32, (m_const / 2 + 1) * 32);
    chk("resets", 32'h2, n_rst);
    rd_chk(WST_OFS_MODE, 32'h5, 32'h4);
    complete_run;
  end
endmodule
